// ===== design/panel_window_writer.sv
// Host side controller: programs shrink, window, pointer and frame pulse settings, then streams pixels.
// Assumes the driver's frame pulse pin and pixel source are synchronous to ref_clk.
`timescale 1ns/1ps
module panel_window_writer import panel_host_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              start,
	input  wire write_cfg_t        cfg,
	input  wire logic              pix_valid,
	input  wire logic [DATA_W-1:0] pix_data,
	output logic                   pix_ready_q,
	output logic                   busy_q,
	output logic                   done_q,
	output logic                   cfg_error_q,
	input  wire logic              frame_sync_pulse,
	output logic                   cs_n,
	output logic                   rs,
	output logic                   wr_n,
	output logic                   rd_n_q,
	output logic [DATA_W-1:0]      db_o,
	output logic                   db_oe
);

	typedef enum logic [3:0] {
		S_IDLE, S_CHECK, S_CFG_ISSUE, S_CFG_WAIT, S_FRAME_WAIT,
		S_IDX_ISSUE, S_IDX_WAIT, S_STREAM, S_PIX_WAIT, S_DONE
	} state_t;

	logic [1:0]   rst_sync_q;
	logic         rst_int_n;
	state_t       state_q;
	state_t       state_d;
	write_cfg_t   cfg_q;
	logic [4:0]   step_q;
	logic [19:0]  pix_left_q;
	logic         frame_prev_q;
	logic         frame_rise;
	logic         eng_idle;
	logic         eng_done;
	logic         req_valid;
	bus_req_t     req;
	bus_req_t     cfg_req;

	// Derived window and shrink values
	logic [1:0]   shift_amt;
	logic [1:0]   surplus_mask;
	logic [9:0]   red_w;
	logic [9:0]   red_h;
	logic [1:0]   surplus_h;
	logic [1:0]   surplus_v;
	logic [10:0]  win_he;
	logic [10:0]  win_ve;
	logic [7:0]   ptr_x;
	logic [8:0]   ptr_y;
	logic         shrink_ok;
	logic         intv_ok;
	logic         cfg_legal;

	// Reset released through two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_q[1];

	// Shrink factor to shift and remainder mask
	always_comb begin
		unique case (cfg_q.shrink_factor)
			SHRINK_HALF: begin
				shift_amt    = 2'h1;
				surplus_mask = 2'h1;
				shrink_ok    = 1'b1;
			end
			SHRINK_QUARTER: begin
				shift_amt    = 2'h2;
				surplus_mask = 2'h3;
				shrink_ok    = 1'b1;
			end
			SHRINK_NONE: begin
				shift_amt    = 2'h0;
				surplus_mask = 2'h0;
				shrink_ok    = 1'b1;
			end
			default: begin
				shift_amt    = 2'h0;
				surplus_mask = 2'h0;
				shrink_ok    = 1'b0;
			end
		endcase
	end

	// Reduced size, surplus pixels and window edges; source stays full size
	assign red_w     = cfg_q.src_w >> shift_amt;
	assign red_h     = cfg_q.src_h >> shift_amt;
	assign surplus_h = cfg_q.src_w[1:0] & surplus_mask;
	assign surplus_v = cfg_q.src_h[1:0] & surplus_mask;
	assign win_he    = {3'h0, cfg_q.org_x} + {1'b0, red_w} - 11'h001;
	assign win_ve    = {2'h0, cfg_q.org_y} + {1'b0, red_h} - 11'h001;

	// Pointer starts at the window corner the stepping direction begins from
	assign ptr_x = cfg_q.h_inc ? cfg_q.org_x : win_he[7:0];
	assign ptr_y = cfg_q.v_inc ? cfg_q.org_y : win_ve[8:0];

	assign intv_ok = (cfg_q.frame_pulse_interval == 3'h0) || (cfg_q.frame_pulse_interval == 3'h1) ||
	                 (cfg_q.frame_pulse_interval == 3'h3) || (cfg_q.frame_pulse_interval == 3'h5);

	// Refuse anything the driver cannot take; waiting on a disabled pulse would hang
	assign cfg_legal = shrink_ok && intv_ok &&
	                   (red_w != 10'h000) && (red_h != 10'h000) &&
	                   (win_he <= WIN_H_MAX) &&
	                   (win_ve <= WIN_V_MAX) &&
	                   (cfg_q.frame_pulse_line <= FRAME_LINE_MAX) &&
	                   (!cfg_q.sync_to_frame || cfg_q.frame_pulse_out_enable);

	// Register programming order: shrink first, pointer before any pixel
	always_comb begin
		logic [7:0]        idx;
		logic [DATA_W-1:0] val;
		idx = IDX_RESIZE;
		val = '0;
		unique case (step_q[4:1])
			4'h0: begin
				idx = IDX_RESIZE;
				val[RSZ_FACTOR_POS +: 2] = cfg_q.shrink_factor;
				val[RSZ_SURP_H_POS +: 2] = surplus_h;
				val[RSZ_SURP_V_POS +: 2] = surplus_v;
			end
			4'h1: begin
				idx = IDX_WIN_HS;
				val = {8'h00, cfg_q.org_x};
			end
			4'h2: begin
				idx = IDX_WIN_HE;
				val = {8'h00, win_he[7:0]};
			end
			4'h3: begin
				idx = IDX_WIN_VS;
				val = {7'h00, cfg_q.org_y};
			end
			4'h4: begin
				idx = IDX_WIN_VE;
				val = {7'h00, win_ve[8:0]};
			end
			4'h5: begin
				idx = IDX_ENTRY;
				val[ENTRY_AXIS_POS] = cfg_q.step_axis_select;
				val[ENTRY_HINC_POS] = cfg_q.h_inc;
				val[ENTRY_VINC_POS] = cfg_q.v_inc;
			end
			4'h6: begin
				idx = IDX_PTR_LO;
				val = {8'h00, ptr_x};
			end
			4'h7: begin
				idx = IDX_PTR_HI;
				val = {7'h00, ptr_y};
			end
			4'h8: begin
				idx = IDX_FRAME;
				val[FRAME_LINE_POS +: 9] = cfg_q.frame_pulse_line;
				val[FRAME_INTV_POS +: 3] = cfg_q.frame_pulse_interval;
				val[FRAME_OE_POS]        = cfg_q.frame_pulse_out_enable;
			end
			default: begin
				idx = IDX_GRAM;
				val = '0;
			end
		endcase
		cfg_req.rs   = step_q[0];
		cfg_req.data = step_q[0] ? val : {8'h00, idx};
	end

	// Frame pulse edge; the pin is taken as synchronous
	always_ff @(posedge ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			frame_prev_q <= 1'b0;
		end else begin
			frame_prev_q <= frame_sync_pulse;
		end
	end
	assign frame_rise = frame_sync_pulse & ~frame_prev_q;

	// Bus request mux
	always_comb begin
		req_valid = 1'b0;
		req       = cfg_req;
		unique case (state_q)
			S_CFG_ISSUE: begin
				req_valid = eng_idle;
			end
			S_IDX_ISSUE: begin
				req_valid = eng_idle;
				req.rs    = 1'b0;
				req.data  = {8'h00, IDX_GRAM};
			end
			S_STREAM: begin
				req_valid = pix_valid & pix_ready_q;
				req.rs    = 1'b1;
				req.data  = pix_data;
			end
			default: begin
				req_valid = 1'b0;
			end
		endcase
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: begin
				if (start) begin
					state_d = S_CHECK;
				end
			end
			S_CHECK: begin
				state_d = cfg_legal ? S_CFG_ISSUE : S_IDLE;
			end
			S_CFG_ISSUE: begin
				if (eng_idle) begin
					state_d = S_CFG_WAIT;
				end
			end
			S_CFG_WAIT: begin
				if (eng_done) begin
					if (step_q == 5'(CFG_STEPS - 1)) begin
						state_d = cfg_q.sync_to_frame ? S_FRAME_WAIT : S_IDX_ISSUE;
					end else begin
						state_d = S_CFG_ISSUE;
					end
				end
			end
			S_FRAME_WAIT: begin
				if (frame_rise) begin
					state_d = S_IDX_ISSUE;
				end
			end
			S_IDX_ISSUE: begin
				if (eng_idle) begin
					state_d = S_IDX_WAIT;
				end
			end
			S_IDX_WAIT: begin
				if (eng_done) begin
					state_d = S_STREAM;
				end
			end
			S_STREAM: begin
				if (req_valid) begin
					state_d = S_PIX_WAIT;
				end
			end
			S_PIX_WAIT: begin
				if (eng_done) begin
					state_d = (pix_left_q == 20'h00001) ? S_DONE : S_STREAM;
				end
			end
			S_DONE: begin
				state_d = S_IDLE;
			end
		endcase
	end

	// State, config latch and step counter
	always_ff @(posedge ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			state_q <= S_IDLE;
			cfg_q   <= '0;
			step_q  <= 5'h00;
		end else begin
			state_q <= state_d;
			if (state_q == S_IDLE && start) begin
				cfg_q  <= cfg;
				step_q <= 5'h00;
			end else if (state_q == S_CFG_WAIT && eng_done) begin
				step_q <= step_q + 5'h01;
			end
		end
	end

	// Whole source frame is sent, so lines always complete
	always_ff @(posedge ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pix_left_q <= 20'h00000;
		end else if (state_q == S_CHECK) begin
			pix_left_q <= {10'h000, cfg_q.src_w} * {10'h000, cfg_q.src_h};
		end else if (state_q == S_PIX_WAIT && eng_done) begin
			pix_left_q <= pix_left_q - 20'h00001;
		end
	end

	// User status flags, all registered
	always_ff @(posedge ref_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			pix_ready_q <= 1'b0;
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			cfg_error_q <= 1'b0;
			rd_n_q      <= 1'b1;
		end else begin
			pix_ready_q <= (state_d == S_STREAM);
			busy_q      <= (state_d != S_IDLE);
			done_q      <= (state_d == S_DONE);
			rd_n_q      <= 1'b1; // Reads are never issued
			if (state_q == S_IDLE && start) begin
				cfg_error_q <= 1'b0;
			end else if (state_q == S_CHECK && !cfg_legal) begin
				cfg_error_q <= 1'b1;
			end
		end
	end

	bus_write_cycle u_bus (
		.clk       (ref_clk),
		.rst_n     (rst_int_n),
		.req_valid (req_valid),
		.req       (req),
		.idle_q    (eng_idle),
		.done_q    (eng_done),
		.cs_n_q    (cs_n),
		.rs_q      (rs),
		.wr_n_q    (wr_n),
		.db_o_q    (db_o),
		.db_oe_q   (db_oe)
	);

endmodule // panel_window_writer

// ===== design/panel_host_pkg.sv
// Constants, field layouts and carrier types shared by the panel write host.
// Assumes a host clock of 10 MHz and a 16-bit write-only system bus to the panel driver.
package panel_host_pkg;

	localparam int DATA_W = 16;

	// Host clock and bus strobe timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int WR_LOW_NS     = 100;
	localparam int WR_HIGH_NS    = 100;
	localparam int WR_LOW_CYC    = ((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
	                               ((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int WR_HIGH_CYC   = ((WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
	                               ((WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Register indices in the driver
	localparam logic [7:0] IDX_RESIZE = 8'h10;
	localparam logic [7:0] IDX_WIN_HS = 8'h11;
	localparam logic [7:0] IDX_WIN_HE = 8'h12;
	localparam logic [7:0] IDX_WIN_VS = 8'h13;
	localparam logic [7:0] IDX_WIN_VE = 8'h14;
	localparam logic [7:0] IDX_ENTRY  = 8'h15;
	localparam logic [7:0] IDX_PTR_LO = 8'h16;
	localparam logic [7:0] IDX_PTR_HI = 8'h17;
	localparam logic [7:0] IDX_FRAME  = 8'h18;
	localparam logic [7:0] IDX_GRAM   = 8'h19;

	// Field positions inside register data words
	localparam int RSZ_FACTOR_POS  = 0;
	localparam int RSZ_SURP_H_POS  = 4;
	localparam int RSZ_SURP_V_POS  = 8;
	localparam int ENTRY_AXIS_POS  = 0;
	localparam int ENTRY_HINC_POS  = 4;
	localparam int ENTRY_VINC_POS  = 5;
	localparam int FRAME_LINE_POS  = 0;
	localparam int FRAME_INTV_POS  = 12;
	localparam int FRAME_OE_POS    = 15;

	// Shrink codes and legal limits
	localparam logic [1:0]  SHRINK_NONE    = 2'h0;
	localparam logic [1:0]  SHRINK_HALF    = 2'h1;
	localparam logic [1:0]  SHRINK_QUARTER = 2'h3;
	localparam logic [10:0] WIN_H_MAX      = 11'h0ef;
	localparam logic [10:0] WIN_V_MAX      = 11'h13f;
	localparam logic [8:0]  FRAME_LINE_MAX = 9'h14f;
	localparam int          CFG_STEPS      = 18;

	typedef struct packed {
		logic [9:0] src_w;
		logic [9:0] src_h;
		logic [7:0] org_x;
		logic [8:0] org_y;
		logic [1:0] shrink_factor;
		logic       step_axis_select;
		logic       h_inc;
		logic       v_inc;
		logic [8:0] frame_pulse_line;
		logic [2:0] frame_pulse_interval;
		logic       frame_pulse_out_enable;
		logic       sync_to_frame;
	} write_cfg_t;

	typedef struct packed {
		logic              rs;
		logic [DATA_W-1:0] data;
	} bus_req_t;

endpackage

// ===== design/bus_write_cycle.sv
// One write cycle on the driver's 80-style system bus: chip select, register select and write strobe.
// Assumes the caller holds req steady only in the cycle req_valid is high while idle_q is set.
`timescale 1ns/1ps
module bus_write_cycle import panel_host_pkg::*; (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	input  wire bus_req_t          req,
	output logic                   idle_q,
	output logic                   done_q,
	output logic                   cs_n_q,
	output logic                   rs_q,
	output logic                   wr_n_q,
	output logic [DATA_W-1:0]      db_o_q,
	output logic                   db_oe_q
);

	typedef enum logic [1:0] {P_IDLE, P_LOW, P_HIGH} phase_t;

	phase_t     phase_q;
	logic [7:0] cnt_q;

	// Strobe sequencer; data held through the high phase for hold time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= P_IDLE;
			cnt_q   <= 8'h00;
			idle_q  <= 1'b1;
			done_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			rs_q    <= 1'b0;
			wr_n_q  <= 1'b1;
			db_o_q  <= '0;
			db_oe_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (phase_q)
				P_IDLE: begin
					if (req_valid) begin
						phase_q <= P_LOW;
						cnt_q   <= 8'(WR_LOW_CYC - 1);
						idle_q  <= 1'b0;
						cs_n_q  <= 1'b0;
						rs_q    <= req.rs;
						wr_n_q  <= 1'b0;
						db_o_q  <= req.data;
						db_oe_q <= 1'b1;
					end
				end
				P_LOW: begin
					if (cnt_q == 8'h00) begin
						phase_q <= P_HIGH;
						cnt_q   <= 8'(WR_HIGH_CYC - 1);
						wr_n_q  <= 1'b1; // Driver latches on this rising edge
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				P_HIGH: begin
					if (cnt_q == 8'h00) begin
						phase_q <= P_IDLE;
						idle_q  <= 1'b1;
						done_q  <= 1'b1;
						cs_n_q  <= 1'b1;
						db_oe_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
			endcase
		end
	end

endmodule // bus_write_cycle

// ===== test/panel_write_monitor.sv
// Checker on the write host's user and bus ports.
// Assumes it is bound into panel_window_writer and sees only its ports.
`timescale 1ns/1ps
module panel_write_monitor import panel_host_pkg::*; (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              start,
	input wire logic              pix_valid,
	input wire logic [DATA_W-1:0] pix_data,
	input wire logic              pix_ready_q,
	input wire logic              busy_q,
	input wire logic              done_q,
	input wire logic              cfg_error_q,
	input wire logic              cs_n,
	input wire logic              rs,
	input wire logic              wr_n,
	input wire logic [DATA_W-1:0] db_o,
	input wire logic              db_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Strobe low one cycle, high one, then deselect
	sequence s_strobe;
		!cs_n && !wr_n ##1 !cs_n && wr_n ##1 cs_n;
	endsequence

	// Accepted pixel leaves at once as a data write
	sequence s_pix_write;
		!pix_ready_q && !cs_n && !wr_n && rs && db_o == $past(pix_data);
	endsequence

	a_strobe_shape: assert property ($fell(wr_n) |-> s_strobe)
		else $error("write strobe shape wrong");
	a_bus_driven: assert property (!cs_n |-> db_oe)
		else $error("bus not driven while selected");
	a_bus_steady: assert property (!cs_n && !$past(cs_n) |-> $stable(rs) && $stable(db_o))
		else $error("bus moved inside a write");
	a_pix_forward: assert property (pix_valid && pix_ready_q |=> s_pix_write)
		else $error("accepted pixel not written");
	a_start_taken: assert property (start && !busy_q |=> busy_q)
		else $error("start not taken");
	a_refuse_timing: assert property ($rose(cfg_error_q) |-> !busy_q && $past(start, 2))
		else $error("refusal timing wrong");
	a_refuse_quiet: assert property (cfg_error_q && !busy_q |-> cs_n)
		else $error("bus used after refusal");
	a_idle_quiet: assert property (!busy_q |-> cs_n && !pix_ready_q)
		else $error("activity while idle");
	a_done_once: assert property (done_q |=> !done_q && !busy_q)
		else $error("done not a single pulse");
endmodule // panel_write_monitor

bind panel_window_writer panel_write_monitor mon (.ref_clk, .rst_n, .start, .pix_valid, .pix_data, .pix_ready_q,
	.busy_q, .done_q, .cfg_error_q, .cs_n, .rs, .wr_n, .db_o, .db_oe);

// ===== test/panel_device_model.sv
// Panel driver model: registers, window write pointer, shrink decimation and frame pulse.
// Assumes writes latch on the rising edge of wr_n while cs_n is low; never read back.
`timescale 1ns/1ps
module panel_device_model import panel_host_pkg::*; #(
	parameter int LINE_CYC = 4, // Short scan line keeps frames brief
	parameter int NLINES   = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              cs_n,
	input  wire logic              rs,
	input  wire logic              wr_n,
	input  wire logic [DATA_W-1:0] db,
	output logic                   frame_sync_pulse
);
	logic [15:0] r [0:31];
	logic [15:0] ram [logic [16:0]];
	logic [15:0] rz, hs, he, vs, ve, en, fm;
	logic [7:0]  idx_q, px;
	logic [8:0]  py;
	int          n, sx, sy, nwr, npix, lc, ln, fr;

	// Named views of the register file
	assign rz = r[IDX_RESIZE[4:0]];
	assign hs = r[IDX_WIN_HS[4:0]];
	assign he = r[IDX_WIN_HE[4:0]];
	assign vs = r[IDX_WIN_VS[4:0]];
	assign ve = r[IDX_WIN_VE[4:0]];
	assign en = r[IDX_ENTRY[4:0]];
	assign fm = r[IDX_FRAME[4:0]];

	initial begin
		frame_sync_pulse = 1'b0;
		foreach (r[i]) r[i] = 16'h0;
	end

	// Next coordinate on one axis, wrapping at the window edge
	function automatic logic [8:0] mv(input logic [8:0] c, lo, hi, input logic inc);
		if (c == (inc ? hi : lo)) return inc ? lo : hi;
		return inc ? c + 9'h1 : c - 9'h1;
	endfunction

	// Step along the chosen axis; an edge moves the other axis once
	task automatic step();
		if (!en[0]) begin
			if (px == (en[4] ? he[7:0] : hs[7:0])) py = mv(py, vs[8:0], ve[8:0], en[5]);
			px = 8'(mv({1'b0, px}, {1'b0, hs[7:0]}, {1'b0, he[7:0]}, en[4]));
		end else begin
			if (py == (en[5] ? ve[8:0] : vs[8:0])) px = 8'(mv({1'b0, px}, {1'b0, hs[7:0]}, {1'b0, he[7:0]}, en[4]));
			py = mv(py, vs[8:0], ve[8:0], en[5]);
		end
	endtask

	// Writes land on the strobe's rising edge, as the driver latches them
	always @(posedge wr_n) if (!cs_n) begin
		nwr++;
		if (!rs) begin
			idx_q = db[7:0];
			sx = 0;
			sy = 0;
		end else if (idx_q != IDX_GRAM) begin
			r[idx_q[4:0]] = db;
			if (idx_q == IDX_PTR_LO) px = db[7:0];
			if (idx_q == IDX_PTR_HI) py = db[8:0];
		end else begin
			npix++;
			n = rz[1:0] == 2'h3 ? 4 : rz[1:0] == 2'h1 ? 2 : 1;
			// Pure decimation, no filter: surplus pixels fall outside the kept range
			if (sx % n == 0 && sy % n == 0 && sx < (he - hs + 1) * n && sy < (ve - vs + 1) * n) begin
				ram[{py, px}] = db;
				step();
			end
			sx++;
			if (sx == (he - hs + 1) * n + rz[5:4]) begin
				sx = 0;
				sy++;
			end
		end
	end

	// Scan counters; the pulse covers one whole line of the chosen frames
	always @(posedge ref_clk) begin
		lc = (lc + 1) % LINE_CYC;
		if (lc == 0) begin
			ln = (ln + 1) % NLINES;
			if (ln == 0) fr++;
		end
		frame_sync_pulse <= fm[15] && ln == fm[8:0] && fr % (fm[14:12] + 1) == 0;
	end
endmodule // panel_device_model

// ===== test/tb_gram_window_resize_framemark.sv
// Self-checking bench for the panel write host against a behavioural panel driver.
// Assumes a 10 MHz ref_clk; every bench input changes on the falling edge, the model's frame_sync_pulse on the rising edge.
`timescale 1ns/1ps
module tb_gram_window_resize_framemark import panel_host_pkg::*; ;
	logic              ref_clk, rst_n, start, pix_valid, pix_ready_q, busy_q, done_q, cfg_error_q;
	logic              frame_sync_pulse, cs_n, rs, wr_n, rd_n_q, db_oe;
	logic [DATA_W-1:0] pix_data, db_o;
	write_cfg_t        cfg, c;
	int                errors, comparisons, pcnt, vc, early, seen, n0, nd, nrd;

	panel_window_writer dut (.ref_clk, .rst_n, .start, .cfg, .pix_valid, .pix_data, .pix_ready_q, .busy_q,
		.done_q, .cfg_error_q, .frame_sync_pulse, .cs_n, .rs, .wr_n, .rd_n_q, .db_o, .db_oe);
	// Undriven bus shows the inverse, so a write latched without drive is caught
	panel_device_model m (.ref_clk, .cs_n, .rs, .wr_n, .db(db_oe ? db_o : ~db_o), .frame_sync_pulse);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Source idles one cycle in three so ready and valid meet at odd moments
	always @(negedge ref_clk) begin
		vc <= vc + 1;
		pix_valid <= vc % 3 != 0;
		pix_data <= 16'ha500 + 16'(pcnt);
	end
	always @(posedge ref_clk) if (pix_valid && pix_ready_q) pcnt++;

	// Job end pulses and any read strobe, counted for the closing checks
	always @(posedge ref_clk) if (done_q === 1'b1) nd++;
	always @(posedge ref_clk) if (rst_n === 1'b1 && rd_n_q !== 1'b1) nrd++;

	// Pixel data ahead of the frame pulse counts as early
	always @(posedge wr_n) if (!cs_n && rs && m.idx_q == IDX_GRAM && seen == 0) early++;
	always @(posedge frame_sync_pulse) seen = 1;

	task automatic check(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		if (errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Registers 10..18 as the driver holds them
	task automatic regs(input logic [15:0] e [9]);
		for (int i = 0; i < 9; i++) check(m.r[16 + i], e[i]);
	endtask

	// One job: start, look for busy, then wait boundedly for the end
	task automatic run(input write_cfg_t x);
		cfg = x;
		pcnt = 0;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		check(busy_q, 1'b1);
		for (int k = 0; busy_q !== 1'b0; k++) begin
			if (k == 4000) begin
				errors++;
				give_verdict();
			end
			@(negedge ref_clk);
		end
	endtask

	initial begin
		seen = 1;
		rst_n = 1'b0;
		start = 1'b0;
		cfg = '0;
		pix_valid = 1'b0;
		pix_data = 16'h0;
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		// Unscaled 3x2 block, horizontal stepping upward
		run('{10'h3, 10'h2, 8'h5, 9'h7, 2'h0, 1'b0, 1'b1, 1'b1, 9'h0, 3'h0, 1'b0, 1'b0});
		regs('{16'h0, 16'h5, 16'h7, 16'h7, 16'h8, 16'h30, 16'h5, 16'h7, 16'h0});
		for (int i = 0; i < 6; i++) check(m.ram[{9'(7 + i / 3), 8'(5 + i % 3)}], 16'ha500 + 16'(i));
		// Half size from 5x5, surplus of one each way, vertical stepping, x downward
		run('{10'h5, 10'h5, 8'ha, 9'h14, 2'h1, 1'b1, 1'b0, 1'b1, 9'h0, 3'h0, 1'b0, 1'b0});
		regs('{16'h111, 16'ha, 16'hb, 16'h14, 16'h15, 16'h21, 16'hb, 16'h14, 16'h0});
		check(m.ram[{9'h14, 8'hb}], 16'ha500);
		check(m.ram[{9'h15, 8'hb}], 16'ha502);
		check(m.ram[{9'h14, 8'ha}], 16'ha50a);
		check(m.ram[{9'h15, 8'ha}], 16'ha50c);
		// Quarter size, writes held back until the frame pulse
		n0 = m.npix;
		seen = 0;
		run('{10'h4, 10'h4, 8'h0, 9'h0, 2'h3, 1'b0, 1'b1, 1'b1, 9'h2, 3'h1, 1'b1, 1'b1});
		regs('{16'h3, 16'h0, 16'h0, 16'h0, 16'h0, 16'h30, 16'h0, 16'h0, 16'h9002});
		check(m.ram[17'h0], 16'ha500);
		check(early, 0);
		check(m.npix - n0, 16);
		// Five illegal settings, each refused without touching the bus
		for (int j = 0; j < 5; j++) begin
			c = '{10'h3, 10'h2, 8'h5, 9'h7, 2'h0, 1'b0, 1'b1, 1'b1, 9'h0, 3'h0, 1'b0, 1'b0};
			case (j)
				0: c.shrink_factor = 2'h2;
				1: c.frame_pulse_interval = 3'h2;
				2: c.frame_pulse_line = 9'h150;
				3: c.sync_to_frame = 1'b1;
				default: c.org_x = 8'hee;
			endcase
			n0 = m.nwr;
			run(c);
			check(cfg_error_q, 1'b1);
			check(m.nwr, n0);
		end
		// Window ending exactly on the last column is legal
		c.org_x = 8'hed;
		run(c);
		check(cfg_error_q, 1'b0);
		check(m.ram[{9'h7, 8'hef}], 16'ha502);
		// Rows from the bottom edge upward, released by a six-frame pulse
		seen = 0;
		run('{10'h2, 10'h2, 8'h20, 9'h30, 2'h0, 1'b0, 1'b1, 1'b0, 9'h5, 3'h5, 1'b1, 1'b1});
		regs('{16'h0, 16'h20, 16'h21, 16'h30, 16'h31, 16'h10, 16'h20, 16'h31, 16'hd005});
		check(m.ram[{9'h31, 8'h20}], 16'ha500);
		check(m.ram[{9'h30, 8'h21}], 16'ha503);
		check(early, 0);
		check(nd, 5);
		check(nrd, 0);
		give_verdict();
	end
endmodule // tb_gram_window_resize_framemark
